// file: core/tce_pkg.sv
// package: constants, carrier structs and state record of the timer channel enable block
package tce_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned DW     = 32;
  localparam int unsigned AW     = 24;
  localparam int unsigned IW     = 22;
  localparam int unsigned NCH    = 4;
  localparam int unsigned MODE_W = 16;

  // ****************************************
  // register indices, byte address is index * 4
  // ****************************************
  localparam logic [IW-1:0] IDX_OVF0     = 22'h0F01A0;
  localparam logic [IW-1:0] IDX_OVF1     = 22'h0F01A2;
  localparam logic [IW-1:0] IDX_OVF2     = 22'h0F01A4;
  localparam logic [IW-1:0] IDX_OVF3     = 22'h0F01A6;
  localparam logic [IW-1:0] IDX_RUN      = 22'h0F01B0;
  localparam logic [IW-1:0] IDX_UPRUN    = 22'h0F01B1;
  localparam logic [IW-1:0] IDX_START    = 22'h0F01B2;
  localparam logic [IW-1:0] IDX_UPSTART  = 22'h0F01B3;
  localparam logic [IW-1:0] IDX_STOP     = 22'h0F01B4;
  localparam logic [IW-1:0] IDX_UPSTOP   = 22'h0F01B5;
  localparam logic [IW-1:0] IDX_MODE     = 22'h0F01C0;
  localparam logic [1:0]    BYTE_OFS     = 2'h0;

  // ****************************************
  // field layout and codes
  // ****************************************
  localparam logic [2:0]     MODE_CAPTURE = 3'h2;
  localparam logic [2:0]     MODE_CAP_ONE = 3'h6;
  localparam int unsigned    MODE_STRIDE  = 4;
  localparam int unsigned    SPLIT_POS    = 3;
  localparam logic [NCH-1:0] MASK_LARGE   = 4'hF;
  localparam logic [NCH-1:0] MASK_SMALL   = 4'h3;
  localparam logic [NCH-1:0] MASK_UPPER   = 4'hA;
  localparam logic [7:0]     RESET_BYTE   = 8'h00;
  localparam logic [MODE_W-1:0] RESET_MODE = 16'h0000;
  localparam logic [DW-1:0]  ZERO_WORD    = 32'h00000000;

  typedef enum logic [3:0] {
    REG_NONE, REG_OVF0, REG_OVF1, REG_OVF2, REG_OVF3, REG_RUN, REG_UPRUN,
    REG_START, REG_UPSTART, REG_STOP, REG_UPSTOP, REG_MODE
  } tce_reg_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } tce_bus_t;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [3:0]    byteenable;
  } tce_av_req_t;

  typedef struct packed {
    logic [NCH-1:0] overflow;
    logic [NCH-1:0] capture;
  } tce_cnt_evt_t;

  typedef struct packed {
    tce_bus_t          bus;
    logic              waitrequest;
    logic [DW-1:0]     readdata;
    logic [NCH-1:0]    ovf;
    logic [NCH-1:0]    ovf_pend;
    logic [NCH-1:0]    run;
    logic [NCH-1:0]    upper_run;
    logic [NCH-1:0]    start_pulse;
    logic [NCH-1:0]    upper_start_pulse;
    logic [MODE_W-1:0] mode_cfg;
  } tce_state_t;

endpackage

// file: core/tce_top.sv
// module: run control, start/stop triggers and capture overflow flags of a four-channel timer

module tce_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire tce_pkg::tce_av_req_t      av_req,
  output logic                           av_waitrequest,
  output logic [tce_pkg::DW-1:0]         av_readdata,
  input  wire tce_pkg::tce_cnt_evt_t     cnt_evt,
  output logic [tce_pkg::NCH-1:0]        channel_run_bit,
  output logic [tce_pkg::NCH-1:0]        upper_half_run_bit,
  output logic [tce_pkg::NCH-1:0]        counter_init,
  output logic [tce_pkg::NCH-1:0]        upper_counter_init,
  output logic [tce_pkg::MODE_W-1:0]     channel_mode_cfg
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic tce_pkg::tce_reg_t reg_decode(input logic [tce_pkg::AW-1:0] a);
    tce_pkg::tce_reg_t r;
    r = tce_pkg::REG_NONE;
    if (a[1:0] == tce_pkg::BYTE_OFS) begin
      unique case (a[tce_pkg::AW-1:2])
        tce_pkg::IDX_OVF0:    r = tce_pkg::REG_OVF0;
        tce_pkg::IDX_OVF1:    r = tce_pkg::REG_OVF1;
        tce_pkg::IDX_OVF2:    r = tce_pkg::REG_OVF2;
        tce_pkg::IDX_OVF3:    r = tce_pkg::REG_OVF3;
        tce_pkg::IDX_RUN:     r = tce_pkg::REG_RUN;
        tce_pkg::IDX_UPRUN:   r = tce_pkg::REG_UPRUN;
        tce_pkg::IDX_START:   r = tce_pkg::REG_START;
        tce_pkg::IDX_UPSTART: r = tce_pkg::REG_UPSTART;
        tce_pkg::IDX_STOP:    r = tce_pkg::REG_STOP;
        tce_pkg::IDX_UPSTOP:  r = tce_pkg::REG_UPSTOP;
        tce_pkg::IDX_MODE:    r = tce_pkg::REG_MODE;
        default:              r = tce_pkg::REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic is_cap_mode(input logic [tce_pkg::MODE_W-1:0] cfg, input int ch);
    logic [2:0] m;
    m = cfg[ch*tce_pkg::MODE_STRIDE +: 3];
    return (m == tce_pkg::MODE_CAPTURE) || (m == tce_pkg::MODE_CAP_ONE);
  endfunction

  // ****************************************
  // state
  // ****************************************
  tce_pkg::tce_state_t st;
  tce_pkg::tce_state_t next_st;

  logic [tce_pkg::NCH-1:0] ch_mask;
  logic [tce_pkg::NCH-1:0] split;
  logic [tce_pkg::NCH-1:0] up_mask;
  logic [tce_pkg::NCH-1:0] cap_mode;
  tce_pkg::tce_reg_t       sel;
  logic                    wr_acc;
  logic                    rd_acc;
  logic [7:0]              wbyte;

  // channels 2 and 3 simply do not exist in the small variant
  assign ch_mask = LARGE_VARIANT ? tce_pkg::MASK_LARGE : tce_pkg::MASK_SMALL;

  genvar g;
  generate
    for (g = 0; g < tce_pkg::NCH; g++) begin : g_ch
      assign split[g]    = st.mode_cfg[g*tce_pkg::MODE_STRIDE + tce_pkg::SPLIT_POS];
      assign cap_mode[g] = is_cap_mode(st.mode_cfg, g);
    end
  endgenerate

  // upper halves only on channels 1 and 3, and only while split
  assign up_mask = tce_pkg::MASK_UPPER & ch_mask & split;

  assign sel    = reg_decode(av_req.address);
  // transfer completes at the edge where waitrequest is low
  assign wr_acc = (st.bus == tce_pkg::BUS_ACK) && av_req.write && av_req.byteenable[0];
  assign rd_acc = (st.bus == tce_pkg::BUS_ACK) && av_req.read;
  assign wbyte  = av_req.writedata[7:0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [tce_pkg::DW-1:0] rd_val;
    rd_val  = tce_pkg::ZERO_WORD;
    next_st = st;
    // trigger bits live one cycle only
    next_st.start_pulse       = '0;
    next_st.upper_start_pulse = '0;

    // read value, sampled when the request is first seen
    unique case (sel)
      tce_pkg::REG_OVF0:  rd_val[0] = st.ovf[0] & ch_mask[0];
      tce_pkg::REG_OVF1:  rd_val[0] = st.ovf[1] & ch_mask[1];
      tce_pkg::REG_OVF2:  rd_val[0] = st.ovf[2] & ch_mask[2];
      tce_pkg::REG_OVF3:  rd_val[0] = st.ovf[3] & ch_mask[3];
      tce_pkg::REG_RUN:   rd_val[tce_pkg::NCH-1:0] = st.run & ch_mask;
      tce_pkg::REG_UPRUN: rd_val[tce_pkg::NCH-1:0] = st.upper_run & tce_pkg::MASK_UPPER & ch_mask;
      tce_pkg::REG_MODE:  rd_val[tce_pkg::MODE_W-1:0] = st.mode_cfg;
      default:            rd_val = tce_pkg::ZERO_WORD;
    endcase

    unique case (st.bus)
      tce_pkg::BUS_IDLE: begin
        if (av_req.read || av_req.write) begin
          next_st.bus         = tce_pkg::BUS_ACK;
          next_st.waitrequest = 1'b0;
          next_st.readdata    = av_req.read ? rd_val : tce_pkg::ZERO_WORD;
        end
      end
      tce_pkg::BUS_ACK: begin
        next_st.bus         = tce_pkg::BUS_IDLE;
        next_st.waitrequest = 1'b1;
      end
    endcase

    // register writes; trigger writes drop reserved and absent bits, mode takes bits 15:8 only when lane 1 is enabled
    if (wr_acc) begin
      unique case (sel)
        tce_pkg::REG_START: begin
          next_st.start_pulse = wbyte[tce_pkg::NCH-1:0] & ch_mask;
          next_st.run         = st.run | next_st.start_pulse;
        end
        tce_pkg::REG_UPSTART: begin
          next_st.upper_start_pulse = wbyte[tce_pkg::NCH-1:0] & up_mask;
          next_st.upper_run         = st.upper_run | next_st.upper_start_pulse;
        end
        tce_pkg::REG_STOP:   next_st.run       = st.run & ~(wbyte[tce_pkg::NCH-1:0] & ch_mask);
        tce_pkg::REG_UPSTOP: next_st.upper_run = st.upper_run & ~(wbyte[tce_pkg::NCH-1:0] & up_mask);
        tce_pkg::REG_MODE: begin
          next_st.mode_cfg[7:0] = wbyte;
          if (av_req.byteenable[1]) begin
            next_st.mode_cfg[15:8] = av_req.writedata[15:8];
          end
        end
        default: next_st.run = st.run;
      endcase
    end

    // overflow since the last capture is only remembered, never shown
    for (int i = 0; i < tce_pkg::NCH; i++) begin
      if (cap_mode[i] && ch_mask[i]) begin
        if (cnt_evt.capture[i]) begin
          // a wrap in the capture cycle counts as before the capture
          next_st.ovf[i]      = st.ovf_pend[i] | cnt_evt.overflow[i];
          next_st.ovf_pend[i] = 1'b0;
        end else if (cnt_evt.overflow[i]) begin
          next_st.ovf_pend[i] = 1'b1;
        end
      end else begin
        next_st.ovf_pend[i] = 1'b0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.bus               <= tce_pkg::BUS_IDLE;
      st.waitrequest       <= 1'b1;
      st.readdata          <= tce_pkg::ZERO_WORD;
      st.ovf               <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.ovf_pend          <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.run               <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.upper_run         <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.start_pulse       <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.upper_start_pulse <= tce_pkg::RESET_BYTE[tce_pkg::NCH-1:0];
      st.mode_cfg          <= tce_pkg::RESET_MODE;
    end else begin
      st <= next_st;
    end
  end

  assign av_waitrequest     = st.waitrequest;
  assign av_readdata        = st.readdata;
  assign channel_run_bit    = st.run;
  assign upper_half_run_bit = st.upper_run;
  // counter reload; start cycle of the count is the datapath's, by mode
  assign counter_init       = st.start_pulse;
  assign upper_counter_init = st.upper_start_pulse;
  assign channel_mode_cfg   = st.mode_cfg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_wait_one;
    (st.bus == tce_pkg::BUS_IDLE) && (av_req.read || av_req.write) |=> !av_waitrequest ##1 av_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low for exactly one cycle");

  property p_ovf_hold;
    !cnt_evt.capture[0] |=> st.ovf[0] == $past(st.ovf[0]);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag moved without capture");

  property p_ovf_set;
    cnt_evt.capture[0] && cap_mode[0] && (st.ovf_pend[0] || cnt_evt.overflow[0]) |=> st.ovf[0];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set at capture");

  property p_ovf_clear;
    cnt_evt.capture[0] && cap_mode[0] && !st.ovf_pend[0] && !cnt_evt.overflow[0] |=> !st.ovf[0];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared at clean capture");

  property p_ovf_mode;
    !cap_mode[1] && !st.ovf[1] |=> !st.ovf[1];
  endproperty
  a_ovf_mode: assert property (p_ovf_mode) else $error("overflow flag set outside capture modes");

  property p_start_run;
    wr_acc && (sel == tce_pkg::REG_START) && wbyte[0] |=> st.run[0] && counter_init[0] ##1 !counter_init[0];
  endproperty
  a_start_run: assert property (p_start_run) else $error("start write did not enable and self-clear");

  property p_stop_run;
    wr_acc && (sel == tce_pkg::REG_STOP) && wbyte[0] |=> !st.run[0];
  endproperty
  a_stop_run: assert property (p_stop_run) else $error("stop write did not clear run bit");

  property p_trig_zero;
    rd_acc && ((sel == tce_pkg::REG_START) || (sel == tce_pkg::REG_STOP)) |-> av_readdata == tce_pkg::ZERO_WORD;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger register read nonzero");

  property p_ovf_bits;
    rd_acc && (sel == tce_pkg::REG_OVF0) |-> av_readdata[tce_pkg::DW-1:1] == '0;
  endproperty
  a_ovf_bits: assert property (p_ovf_bits) else $error("overflow status upper bits nonzero");

  property p_upper;
    wr_acc && (sel == tce_pkg::REG_UPSTART) && wbyte[1] && split[1] |=> st.upper_run[1] && !counter_init[1];
  endproperty
  a_upper: assert property (p_upper) else $error("upper start did not enable only upper half");

  property p_variant;
    ((st.run | st.upper_run) & ~ch_mask) == '0;
  endproperty
  a_variant: assert property (p_variant) else $error("absent channel enabled");

  property p_ovf_flag;
    rd_acc && (sel == tce_pkg::REG_OVF3) |-> av_readdata[0] == ($past(st.ovf[3]) & ch_mask[3]);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow status bit 0 differs from flag");

  property p_ovf_bits3;
    rd_acc && (sel == tce_pkg::REG_OVF3) |-> av_readdata[tce_pkg::DW-1:1] == '0;
  endproperty
  a_ovf_bits3: assert property (p_ovf_bits3) else $error("channel 3 overflow status upper bits nonzero");

  property p_run_read;
    rd_acc && (sel == tce_pkg::REG_RUN) |->
      (av_readdata[tce_pkg::NCH-1:0] == ($past(st.run) & ch_mask)) &&
      (av_readdata[tce_pkg::DW-1:tce_pkg::NCH] == '0);
  endproperty
  a_run_read: assert property (p_run_read) else $error("run status read differs from run bits");

  property p_uprun_read;
    rd_acc && (sel == tce_pkg::REG_UPRUN) |->
      (av_readdata[tce_pkg::NCH-1:0] == ($past(st.upper_run) & tce_pkg::MASK_UPPER & ch_mask)) &&
      (av_readdata[tce_pkg::DW-1:tce_pkg::NCH] == '0);
  endproperty
  a_uprun_read: assert property (p_uprun_read) else $error("upper run status read wrong");

  property p_upper_pos;
    (upper_half_run_bit & ~tce_pkg::MASK_UPPER) == '0;
  endproperty
  a_upper_pos: assert property (p_upper_pos) else $error("upper run bit outside channels 1 and 3");

  property p_start_self;
    counter_init != '0 |=> counter_init == '0;
  endproperty
  a_start_self: assert property (p_start_self) else $error("start pulse lasted more than one cycle");

  property p_upstart_self;
    upper_counter_init != '0 |=> upper_counter_init == '0;
  endproperty
  a_upstart_self: assert property (p_upstart_self) else $error("upper start pulse lasted too long");

  property p_init_run;
    (counter_init & ~channel_run_bit) == '0;
  endproperty
  a_init_run: assert property (p_init_run) else $error("counter reload on a stopped channel");

  property p_upinit_run;
    (upper_counter_init & ~upper_half_run_bit) == '0;
  endproperty
  a_upinit_run: assert property (p_upinit_run) else $error("upper reload on a stopped half");

  property p_lower_only;
    wr_acc && (sel == tce_pkg::REG_START) |=> $stable(upper_half_run_bit) && (upper_counter_init == '0);
  endproperty
  a_lower_only: assert property (p_lower_only) else $error("start write touched an upper half");

  property p_split_lower;
    wr_acc && (sel == tce_pkg::REG_UPSTART) |=> $stable(channel_run_bit) && (counter_init == '0);
  endproperty
  a_split_lower: assert property (p_split_lower) else $error("upper start touched a lower run bit");

  property p_byte_lane;
    (st.bus == tce_pkg::BUS_ACK) && av_req.write && !av_req.byteenable[0] |=>
      $stable(channel_run_bit) && $stable(upper_half_run_bit) && (counter_init == '0);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("write without lane 0 took effect");

  property p_run_ro;
    wr_acc && (sel == tce_pkg::REG_RUN) |=> $stable(channel_run_bit);
  endproperty
  a_run_ro: assert property (p_run_ro) else $error("write to run status changed it");

  property p_ovf_mode2;
    !cap_mode[2] && !st.ovf[2] |=> !st.ovf[2];
  endproperty
  a_ovf_mode2: assert property (p_ovf_mode2) else $error("channel 2 flag set outside capture modes");

  property p_pend_clear;
    cnt_evt.capture[0] |=> !st.ovf_pend[0];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending overflow kept after capture");

  property p_pend_arm;
    cap_mode[0] && ch_mask[0] && cnt_evt.overflow[0] && !cnt_evt.capture[0] |=> st.ovf_pend[0];
  endproperty
  a_pend_arm: assert property (p_pend_arm) else $error("wrap not remembered until capture");

  property p_reset_state;
    $rose(rstn) |-> (channel_run_bit == '0) && (upper_half_run_bit == '0) && (counter_init == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("run or start state not clear after reset");

  property p_init_mask;
    ((counter_init | upper_counter_init) & ~ch_mask) == '0;
  endproperty
  a_init_mask: assert property (p_init_mask) else $error("reload on an absent channel");

  property p_stop_upper;
    wr_acc && (sel == tce_pkg::REG_UPSTOP) && wbyte[1] && up_mask[1] |=> !upper_half_run_bit[1];
  endproperty
  a_stop_upper: assert property (p_stop_upper) else $error("upper stop did not clear upper run bit");

  property p_start_upper3;
    wr_acc && (sel == tce_pkg::REG_UPSTART) && wbyte[3] && up_mask[3] |=>
      upper_half_run_bit[3] && upper_counter_init[3];
  endproperty
  a_start_upper3: assert property (p_start_upper3) else $error("upper start on channel 3 failed");

  property p_ovf_set3;
    cnt_evt.capture[3] && cap_mode[3] && ch_mask[3] && st.ovf_pend[3] |=> st.ovf[3];
  endproperty
  a_ovf_set3: assert property (p_ovf_set3) else $error("channel 3 flag not set at capture");

  c_ovf_set:   cover property (cnt_evt.capture[0] && cap_mode[0] && st.ovf_pend[0] ##1 st.ovf[0]);
  c_start:     cover property (wr_acc && (sel == tce_pkg::REG_START) ##1 counter_init != '0);
  c_upper:     cover property (wr_acc && (sel == tce_pkg::REG_UPSTART) ##1 upper_half_run_bit[3]);
  c_stop_read: cover property (wr_acc && (sel == tce_pkg::REG_STOP) ##2 rd_acc && (sel == tce_pkg::REG_RUN));
  c_clean_cap: cover property (cnt_evt.capture[0] && st.ovf[0] && !st.ovf_pend[0] && !cnt_evt.overflow[0] ##1 !st.ovf[0]);

endmodule

// file: dv/testbench.sv
// testbench: register-level checks of the timer channel enable block over the Avalon bus
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals and instances
  // ****************************************
  logic                  mclk    = 1'b0;
  logic                  rstn    = 1'b0;
  tce_pkg::tce_av_req_t  av_req  = '0;
  tce_pkg::tce_cnt_evt_t cnt_evt = '0;
  logic                  wreq;
  logic                  s_wreq;
  logic [31:0]           rdata;
  logic [31:0]           s_rdata;
  logic [3:0]            run;
  logic [3:0]            uprun;
  logic [3:0]            cinit;
  logic [3:0]            ucinit;
  logic [3:0]            s_run;
  logic [3:0]            init_seen  = 4'h0;
  logic [3:0]            uinit_seen = 4'h0;
  logic [31:0]           q;
  logic [31:0]           qs;
  logic [3:0]            ovf_exp;
  logic [15:0]           mcfg;
  int                    fails   = 0;
  int                    n_checks = 0;

  tce_top u_tce_top (.mclk(mclk), .rstn(rstn), .av_req(av_req), .av_waitrequest(wreq), .av_readdata(rdata),
    .cnt_evt(cnt_evt), .channel_run_bit(run), .upper_half_run_bit(uprun), .counter_init(cinit),
    .upper_counter_init(ucinit), .channel_mode_cfg(mcfg));
  // small variant shares the bus; its answer has the same timing
  tce_top #(.LARGE_VARIANT(1'b0)) u_tce_top_small (.mclk(mclk), .rstn(rstn), .av_req(av_req),
    .av_waitrequest(s_wreq), .av_readdata(s_rdata), .cnt_evt(cnt_evt), .channel_run_bit(s_run),
    .upper_half_run_bit(), .counter_init(), .upper_counter_init(), .channel_mode_cfg());

  always #20 mclk = ~mclk;

  // pulses last one cycle, so they are collected sticky
  always @(posedge mclk) begin
    init_seen  <= init_seen | cinit;
    uinit_seen <= uinit_seen | ucinit;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one whole transfer; an edge always passes before a new request is raised
  task automatic bus(input logic wr, input logic [21:0] idx, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    av_req.read       <= ~wr;
    av_req.write      <= wr;
    av_req.address    <= {idx, tce_pkg::BYTE_OFS};
    av_req.writedata  <= d;
    av_req.byteenable <= be;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q  = rdata;
    qs = s_rdata;
    chk({31'h0, s_wreq}, 32'h00000000);
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [21:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [21:0] idx);
    bus(1'b0, idx, 32'h00000000, 4'hF);
  endtask

  task automatic evt(input logic [3:0] ov, input logic [3:0] cp);
    @(posedge mclk);
    cnt_evt <= '{overflow: ov, capture: cp};
    @(posedge mclk);
    cnt_evt <= '0;
  endtask

  initial begin
    #200000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    logic [21:0] regs [11];
    regs = '{tce_pkg::IDX_OVF0, tce_pkg::IDX_OVF1, tce_pkg::IDX_OVF2, tce_pkg::IDX_OVF3, tce_pkg::IDX_RUN,
      tce_pkg::IDX_UPRUN, tce_pkg::IDX_START, tce_pkg::IDX_UPSTART, tce_pkg::IDX_STOP, tce_pkg::IDX_UPSTOP,
      tce_pkg::IDX_MODE};
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(regs[i]);
      chk(q, 32'h00000000);
    end
    wr(tce_pkg::IDX_START, 32'h00000001);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000001);
    chk({28'h0, run}, 32'h00000001);
    chk({28'h0, init_seen}, 32'h00000001);
    chk({28'h0, cinit}, 32'h00000000);
    // lane 0 off: the write must not land
    bus(1'b1, tce_pkg::IDX_START, 32'h000000FF, 4'hE);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000001);
    wr(tce_pkg::IDX_START, 32'h000000FF);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h0000000F);
    chk(qs, 32'h00000003);
    chk({28'h0, s_run}, 32'h00000003);
    chk({28'h0, init_seen}, 32'h0000000F);
    rd(tce_pkg::IDX_START);
    chk(q, 32'h00000000);
    wr(tce_pkg::IDX_RUN, 32'h00000000);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h0000000F);
    wr(tce_pkg::IDX_STOP, 32'h00000005);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h0000000A);
    rd(tce_pkg::IDX_STOP);
    chk(q, 32'h00000000);
    // reset in mid-run stops every channel
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000000);
    chk({28'h0, run}, 32'h00000000);
    // ch0 capture, ch3 capture plus one count, ch1 and ch2 interval
    wr(tce_pkg::IDX_MODE, 32'h00006002);
    rd(tce_pkg::IDX_MODE);
    chk(q, 32'h00006002);
    chk({16'h0, mcfg}, 32'h00006002);
    evt(4'hF, 4'h0);
    rd(tce_pkg::IDX_OVF0);
    chk(q, 32'h00000000);
    evt(4'h0, 4'hF);
    ovf_exp = 4'h9;
    for (int i = 0; i < 4; i++) begin
      rd(regs[i]);
      chk(q, {31'h0, ovf_exp[i]});
    end
    evt(4'h0, 4'h1);
    rd(tce_pkg::IDX_OVF0);
    chk(q, 32'h00000000);
    evt(4'h1, 4'h1);
    rd(tce_pkg::IDX_OVF0);
    chk(q, 32'h00000001);
    wr(tce_pkg::IDX_OVF0, 32'h00000000);
    rd(tce_pkg::IDX_OVF0);
    chk(q, 32'h00000001);
    // split channels 1 and 3 into two halves
    wr(tce_pkg::IDX_MODE, 32'h00008080);
    wr(tce_pkg::IDX_UPSTART, 32'h000000FF);
    rd(tce_pkg::IDX_UPRUN);
    chk(q, 32'h0000000A);
    chk({28'h0, uinit_seen}, 32'h0000000A);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000000);
    wr(tce_pkg::IDX_START, 32'h00000002);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000002);
    chk({28'h0, uprun}, 32'h0000000A);
    rd(tce_pkg::IDX_UPSTART);
    chk(q, 32'h00000000);
    wr(tce_pkg::IDX_UPSTOP, 32'h00000002);
    rd(tce_pkg::IDX_UPRUN);
    chk(q, 32'h00000008);
    wr(tce_pkg::IDX_STOP, 32'h00000002);
    rd(tce_pkg::IDX_RUN);
    chk(q, 32'h00000000);
    chk({28'h0, uprun}, 32'h00000008);
    rd(22'h0F0200);
    chk(q, 32'h00000000);
    end_sim();
  end
endmodule
